// [hw/cesr_regs.v]
// contactless error, interrupt-enable and link status register bank
`timescale 1ns/10ps
`include "cesr_map.vh"
module cesr_regs #(
    parameter TIMERS = 5
) (
    input  wire              REF_CLK_I,
    input  wire              RST_I,
    input  wire [7:0]        ADDR_I,
    input  wire [7:0]        WDATA_I,
    input  wire              WR_I,
    input  wire              RD_I,
    output reg  [7:0]        RDATA_O,
    input  wire              CARD_DETECT_REQ_I,
    input  wire [TIMERS-1:0] TIMER_UFL_REQ_I,
    input  wire              NVM_CMD_DONE_I,
    input  wire              NVM_CMD_FAIL_I,
    input  wire              FIFO_WR_I,
    input  wire              FIFO_FULL_I,
    input  wire              FIFO_EMPTY_I,
    input  wire              CRC_TX_I,
    input  wire              CMD_START_I,
    input  wire              CMD_RECEIVE_I,
    input  wire              CMD_TRANSCEIVE_I,
    input  wire              AUTH_CMD_ACTIVE_I,
    input  wire              AUTH_CIPHER_SET_I,
    input  wire              ERR_APPENDED_I,
    input  wire              TX_REQ_I,
    input  wire              TX_DONE_I,
    input  wire              TX_GAP_DONE_I,
    input  wire              RX_WAIT_DONE_I,
    input  wire              SOF_I,
    input  wire              RX_BIT_I,
    input  wire              RX_BYTE_I,
    input  wire              RX_EOF_I,
    input  wire              COLL_I,
    input  wire              COLL_IN_EOF_I,
    input  wire [6:0]        COLL_BITPOS_I,
    input  wire              STOP_BIT_ERR_I,
    input  wire              SOF_EOF_ERR_I,
    input  wire              BYTE_COUNT_ERR_I,
    input  wire              PARITY_ERR_I,
    input  wire              CRC_ERR_I,
    output wire              FIFO_WR_ACCEPT_O,
    output wire              RX_BYTE_STORE_O,
    output reg               RX_IRQ_O,
    output wire              RECEIVE_DECODER_EN_O,
    output wire              COMBINED_IRQ_FLAG_O,
    output reg               IRQ_PIN_O,
    output reg               IRQ_PIN_OE_N_O
);
    reg  [7:0] irq_en_reg;
    reg  [7:0] err_reg;
    reg  [7:0] err_next;
    reg        cipher_reg;
    reg  [2:0] state_reg;
    reg  [2:0] state_next;
    reg  [7:0] rxctrl_reg;
    reg  [7:0] ctrl_reg;
    reg  [7:0] coll_pos_reg;
    reg        fifo_block_reg;
    reg  [2:0] bit_cnt_reg;
    reg  [1:0] byte_cnt_reg;
    wire       pin_raw;
    wire       card_s;
    wire [TIMERS-1:0] tmr_s;
    wire       wr_en2;
    wire       wr_st;
    wire       rx_clear;
    wire       rx_active;
    wire       prot_hit;
    wire       short_frame;
    wire       coll_hit;
    wire       any_req;

    // pin inputs from outside the clock domain
    cesr_sync3 #(.W(1)) u_sync_card (
        .clk_i (REF_CLK_I),
        .rst_i (RST_I),
        .d_i   (CARD_DETECT_REQ_I),
        .q_o   (card_s)
    );
    cesr_sync3 #(.W(TIMERS)) u_sync_tmr (
        .clk_i (REF_CLK_I),
        .rst_i (RST_I),
        .d_i   (TIMER_UFL_REQ_I),
        .q_o   (tmr_s)
    );

    assign wr_en2 = WR_I && (ADDR_I == `CESR_ADDR_IRQ_EN2);
    assign wr_st  = WR_I && (ADDR_I == `CESR_ADDR_STATUS);

    // link state machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `CESR_LS_IDLE: begin
                if (CMD_START_I && CMD_RECEIVE_I) begin
                    state_next = `CESR_LS_RXWAIT;
                end else if (CMD_START_I && CMD_TRANSCEIVE_I) begin
                    state_next = `CESR_LS_TXWAIT;
                end
            end
            `CESR_LS_TXWAIT: begin
                if (TX_REQ_I) begin
                    state_next = FIFO_EMPTY_I ? `CESR_LS_IDLE : `CESR_LS_TX;
                end
            end
            `CESR_LS_TX: begin
                if (TX_DONE_I) begin
                    state_next = `CESR_LS_RXWAIT;
                end
            end
            `CESR_LS_RXWAIT: begin
                if (RX_WAIT_DONE_I || TX_GAP_DONE_I) begin
                    state_next = `CESR_LS_WAITDATA;
                end
            end
            `CESR_LS_WAITDATA: begin
                if (SOF_I) begin
                    state_next = `CESR_LS_RX;
                end
            end
            `CESR_LS_RX: begin
                if (prot_hit) begin
                    state_next = `CESR_LS_IDLE;
                end else if (RX_EOF_I) begin
                    state_next = short_frame ? `CESR_LS_WAITDATA : `CESR_LS_IDLE;
                end
            end
            default: state_next = `CESR_LS_IDLE;
        endcase
    end

    assign rx_active = (state_reg == `CESR_LS_RX);
    assign rx_clear  = (CMD_START_I && CMD_RECEIVE_I) ||
                       (state_next == `CESR_LS_WAITDATA && state_reg != `CESR_LS_WAITDATA
                        && state_reg != `CESR_LS_RX);
    assign prot_hit  = rx_active && (STOP_BIT_ERR_I || SOF_EOF_ERR_I || BYTE_COUNT_ERR_I);
    assign short_frame = (byte_cnt_reg == 2'h0 && bit_cnt_reg < `CESR_MIN_BITS) ||
                         (ctrl_reg[`CESR_CTRL_EMD_BIT] &&
                          byte_cnt_reg < `CESR_MIN_EMD_BYTES);
    assign coll_hit  = rx_active && COLL_I && !COLL_IN_EOF_I;
    assign RX_BYTE_STORE_O = RX_BYTE_I && rx_active && !prot_hit;
    assign RECEIVE_DECODER_EN_O = (state_reg == `CESR_LS_WAITDATA) || rx_active;
    assign FIFO_WR_ACCEPT_O = FIFO_WR_I && !FIFO_FULL_I && !fifo_block_reg;

    // error flags; sets win over clears
    always @* begin
        err_next = err_reg;
        if (NVM_CMD_DONE_I) begin
            err_next[`CESR_ERR_NVM_BIT] = NVM_CMD_FAIL_I;
        end
        if (ctrl_reg[`CESR_CTRL_MULTI_BIT] ? ERR_APPENDED_I : CMD_START_I) begin
            err_next[`CESR_ERR_WRVIOL_BIT] = 1'b0;
        end
        if (CMD_START_I) begin
            err_next[`CESR_ERR_OVFL_BIT]   = 1'b0;
            err_next[`CESR_ERR_NODATA_BIT] = 1'b0;
        end
        if (rx_clear) begin
            err_next[`CESR_ERR_SHORT_BIT] = 1'b0;
            err_next[`CESR_ERR_COLL_BIT]  = 1'b0;
            err_next[`CESR_ERR_PROT_BIT]  = 1'b0;
            err_next[`CESR_ERR_INTEG_BIT] = 1'b0;
        end
        if (FIFO_WR_I && (CRC_TX_I || state_reg[2] || AUTH_CMD_ACTIVE_I)) begin
            err_next[`CESR_ERR_WRVIOL_BIT] = 1'b1;
        end
        if (FIFO_WR_I && FIFO_FULL_I) begin
            err_next[`CESR_ERR_OVFL_BIT] = 1'b1;
        end
        if (rx_active && RX_EOF_I && !prot_hit && short_frame) begin
            err_next[`CESR_ERR_SHORT_BIT] = 1'b1;
        end
        if (state_reg == `CESR_LS_TXWAIT && TX_REQ_I && FIFO_EMPTY_I) begin
            err_next[`CESR_ERR_NODATA_BIT] = 1'b1;
        end
        if (coll_hit) begin
            err_next[`CESR_ERR_COLL_BIT] = 1'b1;
            if (rxctrl_reg[`CESR_RX_COLLISION_AS_INTEGRITY_BIT]) begin
                err_next[`CESR_ERR_INTEG_BIT] = 1'b1;
            end
        end
        if (prot_hit) begin
            err_next[`CESR_ERR_PROT_BIT] = 1'b1;
        end
        if (rx_active && (PARITY_ERR_I || CRC_ERR_I)) begin
            err_next[`CESR_ERR_INTEG_BIT] = 1'b1;
        end
    end

    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_en_reg     <= `CESR_RST_IRQ_EN2;
            err_reg        <= 8'h00;
            cipher_reg     <= 1'b0;
            state_reg      <= `CESR_LS_IDLE;
            rxctrl_reg     <= `CESR_RST_RXCTRL;
            ctrl_reg       <= `CESR_RST_CTRL;
            coll_pos_reg   <= 8'h00;
            fifo_block_reg <= 1'b0;
            bit_cnt_reg    <= 3'h0;
            byte_cnt_reg   <= 2'h0;
            RX_IRQ_O       <= 1'b0;
            RDATA_O        <= 8'h00;
        end else begin
            state_reg <= state_next;
            err_reg   <= err_next;
            if (wr_en2) begin
                irq_en_reg <= WDATA_I;
            end
            if (WR_I && ADDR_I == `CESR_ADDR_RXCTRL) begin
                rxctrl_reg <= WDATA_I;
            end
            if (WR_I && ADDR_I == `CESR_ADDR_CTRL) begin
                ctrl_reg <= WDATA_I & 8'h07;
            end
            if (AUTH_CIPHER_SET_I) begin
                cipher_reg <= 1'b1;
            end else if (wr_st && !WDATA_I[`CESR_ST_CIPHER_BIT]) begin
                cipher_reg <= 1'b0;
            end
            if (FIFO_WR_I && FIFO_FULL_I) begin
                fifo_block_reg <= 1'b1;
            end else if (CMD_START_I) begin
                fifo_block_reg <= 1'b0;
            end
            if (rx_clear) begin
                coll_pos_reg <= 8'h00;
            end else if (coll_hit && !coll_pos_reg[7]) begin
                coll_pos_reg <= {1'b1, COLL_BITPOS_I};
            end
            // frame length counting for short-frame checks
            if (state_reg != `CESR_LS_RX) begin
                bit_cnt_reg  <= 3'h0;
                byte_cnt_reg <= 2'h0;
            end else begin
                if (RX_BIT_I && bit_cnt_reg != 3'h7) begin
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                end
                if (RX_BYTE_I && byte_cnt_reg != 2'h3) begin
                    byte_cnt_reg <= byte_cnt_reg + 2'h1;
                end
            end
            RX_IRQ_O <= rx_active && ((RX_EOF_I && !short_frame) || prot_hit);
            RDATA_O  <= 8'h00;
            if (RD_I) begin
                case (ADDR_I)
                    `CESR_ADDR_IRQ_EN2: RDATA_O <= irq_en_reg;
                    `CESR_ADDR_ERROR:   RDATA_O <= err_reg;
                    `CESR_ADDR_STATUS:  RDATA_O <= {2'b00, cipher_reg, 2'b00, state_reg};
                    `CESR_ADDR_RXCTRL:  RDATA_O <= rxctrl_reg;
                    `CESR_ADDR_COLLPOS: RDATA_O <= coll_pos_reg;
                    `CESR_ADDR_CTRL:    RDATA_O <= ctrl_reg;
                    default:            RDATA_O <= 8'h00;
                endcase
            end
        end
    end

    assign any_req = (card_s && irq_en_reg[`CESR_EN_CARD_BIT]) ||
                     (|(tmr_s & irq_en_reg[TIMERS-1:0]));
    assign COMBINED_IRQ_FLAG_O = any_req;

    // interrupt pin driver
    assign pin_raw = (any_req && irq_en_reg[`CESR_EN_PIN_BIT])
                     ^ ctrl_reg[`CESR_CTRL_INV_BIT];
    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            IRQ_PIN_O      <= 1'b0;
            IRQ_PIN_OE_N_O <= 1'b1;
        end else begin
            IRQ_PIN_O <= pin_raw;
            if (irq_en_reg[`CESR_EN_DRIVE_BIT]) begin
                IRQ_PIN_OE_N_O <= 1'b0;
            end else begin
                IRQ_PIN_OE_N_O <= pin_raw;
            end
        end
    end
endmodule // cesr_regs

// [hw/cesr_map.vh]
// register map, field positions and reset values of the error/status register bank
// Notes on behaviour
// - enable bit 7 high drives interrupt pin push-pull, low makes it open-drain
// - combined flag reaches the pin only while enable bit 6 is one
// - card-detect request joins combined flag only while enable bit 5 is one
// - enable bits 4..0 gate timer 4..0 underflow requests into combined flag
// - error register at 0Ah; bit 7 flags failed last nvm command
// - bit 6 set on fifo write during crc, receive phases or authentication
// - bit 6 cleared at command start, in multi-frame mode only after error append instead
// - write into full fifo sets bit 5; later writes discarded, contents kept
// - under 4 bits after start-of-frame sets bit 4, drops frame silently
// - with disturbance suppression, frames under 3 bytes dropped silently too
// - bits 4,2,1,0 clear on receive start or transceive wait-for-data entry
// - transmit request with empty fifo sets bit 3
// - collision sets bit 2, records first position, not inside end-of-frame
// - stop bit, type-B frame or byte count fault sets bit 1, stops receive
// - byte in flight at protocol error is not stored into fifo
// - parity or crc fault sets bit 0, reception continues
// - collision also sets bit 0 while collision-as-integrity is set
// - status at 0Bh: bit 5 cipher active, bits 2..0 link state
// - link state codes 000,001,011,101,110,111; 010 and 100 unused
// - only authentication sets cipher active; software write of zero clears it
// - combined flag set whenever any enabled request is active
// - polarity invert bit inverts the interrupt pin level
`ifndef CESR_MAP_VH
`define CESR_MAP_VH
`define CESR_ADDR_IRQ_EN2    8'h09
`define CESR_ADDR_ERROR      8'h0A
`define CESR_ADDR_STATUS     8'h0B
`define CESR_ADDR_RXCTRL     8'h0C
`define CESR_ADDR_COLLPOS    8'h0D
`define CESR_ADDR_CTRL       8'h0E
`define CESR_RST_IRQ_EN2     8'h00
`define CESR_RST_RXCTRL      8'h00
`define CESR_RST_CTRL        8'h00
`define CESR_EN_DRIVE_BIT    7
`define CESR_EN_PIN_BIT      6
`define CESR_EN_CARD_BIT     5
`define CESR_ERR_NVM_BIT     7
`define CESR_ERR_WRVIOL_BIT  6
`define CESR_ERR_OVFL_BIT    5
`define CESR_ERR_SHORT_BIT   4
`define CESR_ERR_NODATA_BIT  3
`define CESR_ERR_COLL_BIT    2
`define CESR_ERR_PROT_BIT    1
`define CESR_ERR_INTEG_BIT   0
`define CESR_ST_CIPHER_BIT   5
`define CESR_RX_COLLISION_AS_INTEGRITY_BIT   3
`define CESR_CTRL_INV_BIT    0
`define CESR_CTRL_MULTI_BIT  1
`define CESR_CTRL_EMD_BIT    2
`define CESR_LS_IDLE         3'h0
`define CESR_LS_TXWAIT       3'h1
`define CESR_LS_TX           3'h3
`define CESR_LS_RXWAIT       3'h5
`define CESR_LS_WAITDATA     3'h6
`define CESR_LS_RX           3'h7
`define CESR_MIN_BITS        3'h4
`define CESR_MIN_EMD_BYTES   2'h3
`endif

// [hw/cesr_sync3.v]
// three-stage input synchroniser
`timescale 1ns/10ps
module cesr_sync3 #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    reg [W-1:0] q_reg;
    genvar g;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
            s3_reg <= {W{1'b0}};
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // a change counts once stages two and three agree
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    q_reg[g] <= 1'b0;
                end else if (s2_reg[g] == s3_reg[g]) begin
                    q_reg[g] <= s3_reg[g];
                end
            end
        end
    endgenerate
    assign q_o = q_reg;
endmodule // cesr_sync3

// [dv/cesr_regs_asserts.sv]
// assertions on the ports of the error/status register bank
`timescale 1ns/10ps
`include "cesr_map.vh"
module cesr_regs_asserts #(
    parameter TIMERS = 5
) (
    input wire              REF_CLK_I,
    input wire              RST_I,
    input wire [7:0]        ADDR_I,
    input wire [7:0]        WDATA_I,
    input wire              WR_I,
    input wire              RD_I,
    input wire [7:0]        RDATA_O,
    input wire              CARD_DETECT_REQ_I,
    input wire [TIMERS-1:0] TIMER_UFL_REQ_I,
    input wire              FIFO_WR_I,
    input wire              FIFO_FULL_I,
    input wire              CMD_START_I,
    input wire              STOP_BIT_ERR_I,
    input wire              FIFO_WR_ACCEPT_O,
    input wire              RX_BYTE_STORE_O,
    input wire              RX_IRQ_O,
    input wire              COMBINED_IRQ_FLAG_O,
    input wire              IRQ_PIN_O,
    input wire              IRQ_PIN_OE_N_O
);
    reg [7:0] en_reg;
    reg       inv_reg;
    // mirror of the enable register and polarity bit
    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            en_reg  <= 8'h00;
            inv_reg <= 1'h0;
        end else if (WR_I && ADDR_I == `CESR_ADDR_IRQ_EN2) begin
            en_reg <= WDATA_I;
        end else if (WR_I && ADDR_I == `CESR_ADDR_CTRL) begin
            inv_reg <= WDATA_I[`CESR_CTRL_INV_BIT];
        end
    end
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    property p_pin_level;
        !$past(RST_I) |-> IRQ_PIN_O == (($past(COMBINED_IRQ_FLAG_O) & $past(en_reg[6])) ^ $past(inv_reg));
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("irq pin level wrong");
    property p_drive;
        !$past(RST_I) |-> IRQ_PIN_OE_N_O == ($past(en_reg[7]) ? 1'h0 : IRQ_PIN_O);
    endproperty
    a_drive: assert property (p_drive) else $error("irq pin drive style wrong");
    property p_comb_off;
        en_reg[5:0] == 6'h00 |-> !COMBINED_IRQ_FLAG_O;
    endproperty
    a_comb_off: assert property (p_comb_off) else $error("flag with no enable");
    property p_card;
        (CARD_DETECT_REQ_I && en_reg[5]) [*5] |-> COMBINED_IRQ_FLAG_O;
    endproperty
    a_card: assert property (p_card) else $error("card request lost");
    property p_timer;
        ($stable(TIMER_UFL_REQ_I) && |(TIMER_UFL_REQ_I & en_reg[TIMERS-1:0])) [*5]
            |-> COMBINED_IRQ_FLAG_O;
    endproperty
    a_timer: assert property (p_timer) else $error("timer request lost");
    property p_no_store;
        STOP_BIT_ERR_I |-> !RX_BYTE_STORE_O;
    endproperty
    a_no_store: assert property (p_no_store) else $error("byte stored on error");
    property p_ovf_block;
        (FIFO_WR_I && FIFO_FULL_I) ##1 !CMD_START_I ##1 FIFO_WR_I |-> !FIFO_WR_ACCEPT_O;
    endproperty
    a_ovf_block: assert property (p_ovf_block) else $error("write after overflow");
    property p_rd_idle;
        !$past(RD_I) |-> RDATA_O == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_rx_pulse;
        RX_IRQ_O |=> !RX_IRQ_O;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx irq too long");
    c_card: cover property (CARD_DETECT_REQ_I && en_reg[5] && COMBINED_IRQ_FLAG_O);
    c_ovf: cover property ((FIFO_WR_I && FIFO_FULL_I) ##2 FIFO_WR_I);
    c_rx_irq: cover property (RX_IRQ_O);
endmodule // cesr_regs_asserts
bind cesr_regs cesr_regs_asserts #(.TIMERS(TIMERS)) u_asserts (.REF_CLK_I, .RST_I, .ADDR_I,
    .WDATA_I, .WR_I, .RD_I, .RDATA_O, .CARD_DETECT_REQ_I, .TIMER_UFL_REQ_I, .FIFO_WR_I,
    .FIFO_FULL_I, .CMD_START_I, .STOP_BIT_ERR_I, .FIFO_WR_ACCEPT_O, .RX_BYTE_STORE_O,
    .RX_IRQ_O, .COMBINED_IRQ_FLAG_O, .IRQ_PIN_O, .IRQ_PIN_OE_N_O);

// [dv/contactless_error_irq_status_regs_tb.sv]
// self-checking bench for the error/status register bank
`timescale 1ns/10ps
module contactless_error_irq_status_regs_tb;
    localparam [15:0] CS = 16'h1, TQ = 16'h2, TD = 16'h4, RW = 16'h8, SF = 16'h10, BT = 16'h20;
    localparam [15:0] BY = 16'h40, EF = 16'h80, PE = 16'h100, PA = 16'h200, CO = 16'h400;
    localparam [15:0] FW = 16'h800, NV = 16'h1000, AU = 16'h2000, AP = 16'h4000, CE = 16'h8000;
    logic REF_CLK_I = 1'h0, RST_I = 1'h1, WR_I, RD_I, CARD_DETECT_REQ_I, NVM_CMD_FAIL_I;
    logic FIFO_FULL_I, FIFO_EMPTY_I, CRC_TX_I, CMD_RECEIVE_I, CMD_TRANSCEIVE_I;
    logic AUTH_CMD_ACTIVE_I, COLL_IN_EOF_I, FIFO_WR_ACCEPT_O, RX_BYTE_STORE_O, RX_IRQ_O;
    logic RECEIVE_DECODER_EN_O, COMBINED_IRQ_FLAG_O, IRQ_PIN_O, IRQ_PIN_OE_N_O, c, st, acc;
    logic [7:0]  ADDR_I, WDATA_I, RDATA_O, r, en;
    logic [4:0]  TIMER_UFL_REQ_I;
    logic [6:0]  COLL_BITPOS_I;
    logic [15:0] ev;
    int          n_fail = 0, samples_checked = 0, n_irq = 0;
    cesr_regs #(.TIMERS(5)) DUT (.REF_CLK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
        .RDATA_O, .CARD_DETECT_REQ_I, .TIMER_UFL_REQ_I, .NVM_CMD_DONE_I(ev[12]),
        .NVM_CMD_FAIL_I, .FIFO_WR_I(ev[11]), .FIFO_FULL_I, .FIFO_EMPTY_I, .CRC_TX_I,
        .CMD_START_I(ev[0]), .CMD_RECEIVE_I, .CMD_TRANSCEIVE_I, .AUTH_CMD_ACTIVE_I,
        .AUTH_CIPHER_SET_I(ev[13]), .ERR_APPENDED_I(ev[14]), .TX_REQ_I(ev[1]), .TX_DONE_I(ev[2]),
        .TX_GAP_DONE_I(1'h0), .RX_WAIT_DONE_I(ev[3]), .SOF_I(ev[4]), .RX_BIT_I(ev[5]),
        .RX_BYTE_I(ev[6]), .RX_EOF_I(ev[7]), .COLL_I(ev[10]), .COLL_IN_EOF_I, .COLL_BITPOS_I,
        .STOP_BIT_ERR_I(ev[8]), .SOF_EOF_ERR_I(1'h0), .BYTE_COUNT_ERR_I(1'h0),
        .PARITY_ERR_I(ev[9]), .CRC_ERR_I(ev[15]), .FIFO_WR_ACCEPT_O, .RX_BYTE_STORE_O,
        .RX_IRQ_O, .RECEIVE_DECODER_EN_O, .COMBINED_IRQ_FLAG_O, .IRQ_PIN_O, .IRQ_PIN_OE_N_O);
    always #12.5 REF_CLK_I = ~REF_CLK_I;
    always @(negedge REF_CLK_I) if (RX_IRQ_O === 1'h1) n_irq++;
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function [1:0] exp_pin(input f, input [7:0] e, input inv);
        exp_pin = {e[7] ? 1'h0 : (f & e[6]) ^ inv, (f & e[6]) ^ inv};
    endfunction
    task chk(input string nm, input [7:0] e, input [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge REF_CLK_I) {ADDR_I, WDATA_I, WR_I} <= {a, d, 1'h1};
        @(posedge REF_CLK_I) WR_I <= 1'h0;
    endtask
    task rd(input [7:0] a, input [7:0] e, input string nm);
        @(posedge REF_CLK_I) {ADDR_I, RD_I} <= {a, 1'h1};
        @(posedge REF_CLK_I) RD_I <= 1'h0;
        @(negedge REF_CLK_I) chk(nm, e, RDATA_O);
        @(posedge REF_CLK_I);
    endtask
    task pulse(input [15:0] m);
        @(posedge REF_CLK_I) ev <= m;
        @(negedge REF_CLK_I) {st, acc} = {RX_BYTE_STORE_O, FIFO_WR_ACCEPT_O};
        @(posedge REF_CLK_I) ev <= 16'h0;
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        close_out;
    end
    initial begin
        {WR_I, RD_I, CARD_DETECT_REQ_I, NVM_CMD_FAIL_I, FIFO_FULL_I, FIFO_EMPTY_I} = 6'h0;
        {CRC_TX_I, CMD_RECEIVE_I, CMD_TRANSCEIVE_I, AUTH_CMD_ACTIVE_I, COLL_IN_EOF_I} = 5'h0;
        {ADDR_I, WDATA_I, TIMER_UFL_REQ_I, COLL_BITPOS_I, ev, r} = {28'h0, 16'h0, 8'h16};
        repeat (4) @(posedge REF_CLK_I);
        RST_I <= 1'h0;
        for (int i = 0; i < 8; i++) rd(8'h09 + i, 8'h00, "reset");
        wr(8'h0A, 8'hFF);
        wr(8'h0B, 8'hFF);
        rd(8'h0A, 8'h00, "error ro");
        rd(8'h0B, 8'h00, "status");
        AUTH_CMD_ACTIVE_I <= 1'h1;
        pulse(FW);
        rd(8'h0A, 8'h40, "auth write");
        AUTH_CMD_ACTIVE_I <= 1'h0;
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            r = lfsr(r);
            en = r;
            r = lfsr(r);
            wr(8'h09, en);
            wr(8'h0E, {7'h0, r[7]});
            @(posedge REF_CLK_I) {CARD_DETECT_REQ_I, TIMER_UFL_REQ_I} <= r[5:0];
            repeat (6) @(posedge REF_CLK_I);
            rd(8'h09, en, "enable");
            c = (r[5] & en[5]) | (|(r[4:0] & en[4:0]));
            chk("combined", c, COMBINED_IRQ_FLAG_O);
            chk("pin", exp_pin(c, en, r[7]), {IRQ_PIN_OE_N_O, IRQ_PIN_O});
        end
        $display("test interrupt done");
        CMD_TRANSCEIVE_I <= 1'h1;
        pulse(CS);
        rd(8'h0B, 8'h01, "txwait");
        CRC_TX_I <= 1'h1;
        pulse(FW);
        rd(8'h0A, 8'h40, "crc write");
        CRC_TX_I <= 1'h0;
        NVM_CMD_FAIL_I <= 1'h1;
        pulse(NV);
        for (int i = 1; i < 5; i++) pulse(16'h1 << i);
        rd(8'h0B, 8'h07, "receiving");
        chk("decoder", 8'h01, RECEIVE_DECODER_EN_O);
        repeat (3) pulse(BT);
        pulse(EF);
        rd(8'h0B, 8'h06, "short frame");
        chk("no irq", 8'h00, n_irq[7:0]);
        COLL_BITPOS_I <= r[6:0];
        pulse(SF);
        pulse(PA);
        COLL_IN_EOF_I <= 1'h1;
        pulse(CO);
        rd(8'h0A, 8'hD1, "eof collision");
        COLL_IN_EOF_I <= 1'h0;
        pulse(CO);
        pulse(BY);
        chk("store", 8'h01, st);
        pulse(PE | BY);
        chk("no store", 8'h00, st);
        rd(8'h0A, 8'hD7, "errors");
        rd(8'h0D, {1'h1, r[6:0]}, "coll pos");
        rd(8'h0B, 8'h00, "stopped");
        chk("rx irq", 8'h01, n_irq[7:0]);
        $display("test transceive done");
        pulse(CS);
        rd(8'h0A, 8'h97, "restart");
        FIFO_EMPTY_I <= 1'h1;
        pulse(TQ);
        rd(8'h0A, 8'h9F, "no data");
        {CMD_RECEIVE_I, CMD_TRANSCEIVE_I, NVM_CMD_FAIL_I} <= 3'h4;
        pulse(NV);
        pulse(CS);
        rd(8'h0A, 8'h00, "rx start");
        FIFO_FULL_I <= 1'h1;
        pulse(FW);
        chk("full accept", 8'h00, acc);
        FIFO_FULL_I <= 1'h0;
        pulse(FW);
        chk("blocked", 8'h00, acc);
        rd(8'h0A, 8'h60, "overflow");
        pulse(CS);
        pulse(FW);
        chk("released", 8'h01, acc);
        rd(8'h0A, 8'h40, "rx write");
        $display("test fifo done");
        pulse(AU);
        rd(8'h0B, 8'h25, "cipher on");
        wr(8'h0B, 8'h00);
        rd(8'h0B, 8'h05, "cipher off");
        $display("test cipher done");
        wr(8'h0C, 8'h08);
        wr(8'h0E, 8'h02);
        pulse(CS);
        rd(8'h0A, 8'h40, "multi keep");
        pulse(AP);
        for (int i = 3; i < 5; i++) pulse(16'h1 << i);
        pulse(CO);
        rd(8'h0A, 8'h05, "coll integ");
        pulse(CS);
        pulse(CE);
        rd(8'h0A, 8'h01, "crc");
        rd(8'h0B, 8'h07, "rx continues");
        $display("test multi-frame done");
        close_out;
    end
endmodule // contactless_error_irq_status_regs_tb
